// File: hw/ofpec_ctrl.sv
// flash program/erase control registers, mode sequencing and protection
// Contract
// - programming writes 128-byte units
// - units start at low byte 00 or 80
// - erase acts on one block only
// - 32k: four 1k blocks plus 28k
// - 16k: four 1k blocks plus 12k
// - boot erases whole array, user per block; hardware erases one block in every mode
// - boot mode matches host bit rate
// - subactive powers supply down, reads allowed
// - five byte registers, two-state byte access
// - flashless variant: reads undefined, writes ignored
// - software protection blocks program and erase
// - write enable low blocks other bits
// - erase needs enable and setup first
// - several block bits set clears all
// - error sets flag and protection state
module ofpec_ctrl
    import ofpec_pkg::*;
#(
    parameter bit IS_32K = 1'b1,
    parameter bit HAS_FLASH = 1'b1,
    parameter int RATE_CNT_W = 16
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // internal byte bus
    input wire logic BUS_SEL,
    input wire logic BUS_WR,
    input wire logic BUS_BYTE,
    input wire logic [15:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    output logic BUS_READY,
    // chip state
    input wire ofpec_pkg::ofpec_mode_t MODE,
    input wire logic SUBACTIVE,
    input wire logic SYS_OSC_ACTIVE,
    input wire logic ARRAY_ERROR,
    // array write unit address
    input wire logic [15:0] ARRAY_ADDR,
    // boot serial line for rate measurement
    input wire logic BOOT_RXD,
    // array control outputs
    output logic PROGRAM_ACTIVE,
    output logic ERASE_ACTIVE,
    output logic [NUM_BLOCKS-1:0] ERASE_BLOCKS,
    output logic UNIT_ALIGNED,
    output logic SUPPLY_DOWN,
    output logic READ_ENABLE,
    output logic [RATE_CNT_W-1:0] BOOT_BIT_PERIOD,
    output logic BOOT_RATE_VALID
);
    import ofpec_pkg::*;

    logic [7:0] ctrl_one_q; // mode bits
    logic error_flag_q; // error flag, sticky until reset
    logic [7:0] power_q; // power control
    logic [7:0] block_sel_q; // erase block select
    logic [7:0] access_q; // access enable
    logic [0:0] state_cnt_q; // bus access state counter
    logic unit_start; // array address on a unit boundary, range included
    logic [RATE_CNT_W-1:0] rate_cnt_q; // low pulse length counter
    logic rxd_q; // previous serial level
    logic rate_busy_q; // measuring a low pulse

    // one-hot or all-zero check for block selects
    function automatic logic one_or_none(input logic [7:0] v);
        one_or_none = ((v & (v - 8'h01)) == 8'h00);
    endfunction : one_or_none

    // register hit helper
    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction : hit

    // address decoding of array unit
    ofpec_map #(.IS_32K(IS_32K)) u_map
    (
        .addr(ARRAY_ADDR),
        .block_hit(),
        .in_array(),
        .unit_start(unit_start)
    );

    // accepted register write: byte only, flash variant only
    logic wr_ok;
    assign wr_ok = BUS_SEL && BUS_WR && BUS_BYTE && HAS_FLASH && (state_cnt_q == BUS_STATES_M1);

    // writes to control registers need access enable, except enable itself
    logic regs_open;
    assign regs_open = access_q[BIT_REGS_ON];

    // software write enable gates the other control one bits, block select and the strobes
    logic write_en;
    assign write_en = ctrl_one_q[BIT_WRITE_EN];

    // two-state access: ready in second state
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            state_cnt_q <= '0;
            BUS_READY <= 1'b0;
        end
        else if (BUS_SEL && !BUS_READY)
        begin
            // ready raised on second state of the access
            state_cnt_q <= state_cnt_q + 1'b1;
            BUS_READY <= (state_cnt_q == BUS_STATES_M1);
        end
        else
        begin
            state_cnt_q <= '0;
            BUS_READY <= 1'b0;
        end
    end

    // control one: write enable guards the other bits
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            ctrl_one_q <= RESET_BYTE;
        end
        else if (error_flag_q)
        begin
            // protection state drops every mode bit but keeps write enable
            ctrl_one_q <= ctrl_one_q & (8'h01 << BIT_WRITE_EN);
        end
        else if (wr_ok && regs_open && hit(BUS_ADDR, ADDR_CTRL_ONE))
        begin
            if (!write_en)
            begin
                // only write enable can be taken while it is low
                ctrl_one_q <= BUS_WDATA & (8'h01 << BIT_WRITE_EN);
            end
            else
            begin
                ctrl_one_q <= BUS_WDATA & CTRL_ONE_MASK;
                // erase enters only after setup already stood
                if (!ctrl_one_q[BIT_ERASE_SETUP])
                begin
                    ctrl_one_q[BIT_ERASE] <= 1'b0;
                end
                if (!ctrl_one_q[BIT_PROG_SETUP])
                begin
                    ctrl_one_q[BIT_PROG] <= 1'b0;
                end
            end
        end
    end

    // error flag: set on array error or wrong clock during an operation
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            error_flag_q <= 1'b0;
        end
        else if ((PROGRAM_ACTIVE || ERASE_ACTIVE) && (ARRAY_ERROR || !SYS_OSC_ACTIVE))
        begin
            error_flag_q <= 1'b1;
        end
    end

    // erase block select: cleared whenever write enable is low
    always_ff @(posedge CLOCK)
    begin
        if (RESET || !write_en)
        begin
            block_sel_q <= RESET_BYTE;
        end
        else if (!one_or_none(block_sel_q))
        begin
            block_sel_q <= RESET_BYTE;
        end
        else if (wr_ok && regs_open && hit(BUS_ADDR, ADDR_BLOCK_SEL))
        begin
            // several bits land, then clear on next edge
            block_sel_q <= BUS_WDATA & BLOCK_MASK;
        end
    end

    // power control and access enable registers
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            power_q <= RESET_BYTE;
            access_q <= RESET_BYTE;
        end
        else if (wr_ok && hit(BUS_ADDR, ADDR_ACCESS_EN))
        begin
            access_q <= BUS_WDATA & ACCESS_MASK;
        end
        else if (wr_ok && regs_open && hit(BUS_ADDR, ADDR_POWER))
        begin
            power_q <= BUS_WDATA & POWER_MASK;
        end
    end

    // read data; flashless variant returns filler since value is undefined
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            BUS_RDATA <= RESET_BYTE;
        end
        else if (!HAS_FLASH || !BUS_SEL || BUS_WR)
        begin
            BUS_RDATA <= RESET_BYTE;
        end
        else if (hit(BUS_ADDR, ADDR_CTRL_ONE))
        begin
            BUS_RDATA <= ctrl_one_q;
        end
        else if (hit(BUS_ADDR, ADDR_CTRL_TWO))
        begin
            BUS_RDATA <= {error_flag_q, 7'h00};
        end
        else if (hit(BUS_ADDR, ADDR_POWER))
        begin
            BUS_RDATA <= power_q;
        end
        else if (hit(BUS_ADDR, ADDR_BLOCK_SEL))
        begin
            BUS_RDATA <= block_sel_q;
        end
        else if (hit(BUS_ADDR, ADDR_ACCESS_EN))
        begin
            BUS_RDATA <= access_q;
        end
        else
        begin
            BUS_RDATA <= RESET_BYTE;
        end
    end

    // array strobes: program a whole aligned unit, erase one block
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            PROGRAM_ACTIVE <= 1'b0;
            ERASE_ACTIVE <= 1'b0;
            ERASE_BLOCKS <= '0;
            UNIT_ALIGNED <= 1'b0;
        end
        else
        begin
            // program only at a unit start, whole 128 bytes follow
            UNIT_ALIGNED <= unit_start;
            PROGRAM_ACTIVE <= write_en && !error_flag_q && ctrl_one_q[BIT_PROG] && unit_start;
            // boot program walks blocks itself; hardware still erases one
            ERASE_ACTIVE <= write_en && !error_flag_q && ctrl_one_q[BIT_ERASE] && ctrl_one_q[BIT_ERASE_SETUP]
                && one_or_none(block_sel_q) && (block_sel_q != 8'h00);
            ERASE_BLOCKS <= block_sel_q[NUM_BLOCKS-1:0];
        end
    end

    // supply power-down in subactive; reads stay allowed
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            SUPPLY_DOWN <= 1'b0;
            READ_ENABLE <= 1'b0;
        end
        else
        begin
            SUPPLY_DOWN <= SUBACTIVE && !power_q[BIT_KEEP_SUPPLY];
            READ_ENABLE <= 1'b1;
        end
    end

    // boot rate: time the start bit low pulse of the host's first byte
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            rxd_q <= 1'b1;
            rate_busy_q <= 1'b0;
            rate_cnt_q <= '0;
            BOOT_BIT_PERIOD <= '0;
            BOOT_RATE_VALID <= 1'b0;
        end
        else
        begin
            rxd_q <= BOOT_RXD;
            if (MODE != OFPEC_BOOT || BOOT_RATE_VALID)
            begin
                rate_busy_q <= 1'b0;
            end
            else if (rxd_q && !BOOT_RXD)
            begin
                rate_busy_q <= 1'b1;
                rate_cnt_q <= '0;
            end
            else if (rate_busy_q && BOOT_RXD)
            begin
                // rising edge ends the start bit: that is one bit time
                rate_busy_q <= 1'b0;
                BOOT_BIT_PERIOD <= rate_cnt_q;
                BOOT_RATE_VALID <= 1'b1;
            end
            else if (rate_busy_q && (rate_cnt_q != '1))
            begin
                rate_cnt_q <= rate_cnt_q + 1'b1;
            end
        end
    end
endmodule : ofpec_ctrl

// File: hw/ofpec_map.sv
// address to erase block decoder and program unit alignment check
module ofpec_map
    import ofpec_pkg::*;
#(
    parameter bit IS_32K = 1'b1
)
(
    // address in
    input wire logic [15:0] addr,
    // decode results
    output logic [NUM_BLOCKS-1:0] block_hit,
    output logic in_array,
    output logic unit_start
);
    // top of array depends on the variant
    localparam logic [15:0] ARRAY_END = IS_32K ? END_32K : END_16K;

    // four 1k blocks low, one large block up to array end
    always_comb
    begin
        block_hit = '0;
        in_array = (addr <= ARRAY_END);
        if (!in_array)
        begin
            block_hit = '0;
        end
        else if (addr <= SMALL_BLOCK_END)
        begin
            block_hit[addr[KBYTE_SHIFT+1:KBYTE_SHIFT]] = 1'b1;
        end
        else
        begin
            block_hit[NUM_BLOCKS-1] = 1'b1;
        end
    end

    // unit starts where low byte is 00 or 80
    assign unit_start = in_array && (addr[$clog2(UNIT_BYTES)-1:0] == '0);
endmodule : ofpec_map

// File: hw/ofpec_pkg.sv
// package: register map, field positions and array geometry of the flash control block
package ofpec_pkg;
    // register byte addresses on the internal bus
    localparam logic [15:0] ADDR_CTRL_ONE = 16'hf020;
    localparam logic [15:0] ADDR_CTRL_TWO = 16'hf021;
    localparam logic [15:0] ADDR_POWER = 16'hf022;
    localparam logic [15:0] ADDR_BLOCK_SEL = 16'hf023;
    localparam logic [15:0] ADDR_ACCESS_EN = 16'hf02b;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // control one fields
    localparam int BIT_WRITE_EN = 6;
    localparam int BIT_ERASE_SETUP = 5;
    localparam int BIT_PROG_SETUP = 4;
    localparam int BIT_ERASE_VERIFY = 3;
    localparam int BIT_PROG_VERIFY = 2;
    localparam int BIT_ERASE = 1;
    localparam int BIT_PROG = 0;
    localparam logic [7:0] CTRL_ONE_MASK = 8'h7f;
    // control two field
    localparam int BIT_ERROR_FLAG = 7;
    // power control: bit 7 keeps the supply up in subactive
    localparam int BIT_KEEP_SUPPLY = 7;
    localparam logic [7:0] POWER_MASK = 8'h80;
    // access enable: bit 7 opens the control registers to writes
    localparam int BIT_REGS_ON = 7;
    localparam logic [7:0] ACCESS_MASK = 8'h80;
    // block select width and mask
    localparam int NUM_BLOCKS = 5;
    localparam logic [7:0] BLOCK_MASK = 8'h1f;
    // geometry
    localparam logic [15:0] SMALL_BLOCK_END = 16'h0fff;
    localparam logic [15:0] END_32K = 16'h7fff;
    localparam logic [15:0] END_16K = 16'h3fff;
    localparam int KBYTE_SHIFT = 10;
    localparam int UNIT_BYTES = 128;
    localparam logic [6:0] UNIT_OFFSET_MASK = 7'h7f;
    // bus access takes two states
    localparam logic [0:0] BUS_STATES_M1 = 1'h1;
    // operating modes
    typedef enum logic [1:0] {OFPEC_BOOT, OFPEC_USER, OFPEC_PROGRAMMER} ofpec_mode_t;
endpackage : ofpec_pkg

// File: tb/ofpec_checker.sv
// checker: bus timing, array decode and protection properties of the flash control block
module ofpec_checker
    import ofpec_pkg::*;
#(
    parameter bit IS_32K = 1'b1
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // bus handshake
    input wire logic BUS_SEL,
    input wire logic BUS_READY,
    // chip state
    input wire logic SUBACTIVE,
    input wire logic SYS_OSC_ACTIVE,
    input wire logic ARRAY_ERROR,
    input wire logic [15:0] ARRAY_ADDR,
    // array control
    input wire logic PROGRAM_ACTIVE,
    input wire logic ERASE_ACTIVE,
    input wire logic [NUM_BLOCKS-1:0] ERASE_BLOCKS,
    input wire logic UNIT_ALIGNED,
    input wire logic SUPPLY_DOWN,
    input wire logic READ_ENABLE,
    input wire logic BOOT_RATE_VALID
);
    timeunit 1ns;
    timeprecision 1ps;
    // last array byte for the chosen size
    localparam logic [15:0] ARR_END = IS_32K ? END_32K : END_16K;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    // ready is registered: low in the first two sampled states, high in the third
    a_ready_two_states: assert property ($rose(BUS_SEL) |-> !BUS_READY ##1 !BUS_READY ##1 BUS_READY)
        else $error("bus ready not in second state");
    a_ready_one_cycle: assert property (BUS_READY |=> !BUS_READY)
        else $error("bus ready longer than one cycle");
    a_ready_has_cause: assert property (BUS_READY |-> $past(BUS_SEL) && $past(BUS_SEL, 2))
        else $error("bus ready without a two state access");
    a_unit_align: assert property (
        !$past(RESET) |-> UNIT_ALIGNED == (($past(ARRAY_ADDR) <= ARR_END) && ($past(ARRAY_ADDR[6:0]) == 7'h00)))
        else $error("unit alignment flag wrong");
    a_supply_idle: assert property (!$past(RESET) && !$past(SUBACTIVE) |-> !SUPPLY_DOWN)
        else $error("supply down outside subactive");
    a_read_allowed: assert property (!$past(RESET) |-> READ_ENABLE)
        else $error("array read disabled");
    a_block_multi: assert property ($countones(ERASE_BLOCKS) > 1 |=> ERASE_BLOCKS == 5'h00)
        else $error("several blocks selected kept");
    a_error_stop: assert property (
        (ARRAY_ERROR || !SYS_OSC_ACTIVE) && (PROGRAM_ACTIVE || ERASE_ACTIVE)
        |-> ##[1:3] !(PROGRAM_ACTIVE || ERASE_ACTIVE))
        else $error("operation not stopped on error");
    a_rate_sticky: assert property (BOOT_RATE_VALID |=> BOOT_RATE_VALID)
        else $error("boot rate valid dropped");
    // main scenarios reached
    c_erase: cover property ($rose(ERASE_ACTIVE));
    c_rate: cover property ($rose(BOOT_RATE_VALID));
    c_multi: cover property ($countones(ERASE_BLOCKS) > 1);
    c_program: cover property ($rose(PROGRAM_ACTIVE));
endmodule : ofpec_checker

bind ofpec_ctrl ofpec_checker #(.IS_32K(IS_32K)) u_chk (.CLOCK(CLOCK), .RESET(RESET), .BUS_SEL(BUS_SEL),
    .BUS_READY(BUS_READY), .SUBACTIVE(SUBACTIVE), .SYS_OSC_ACTIVE(SYS_OSC_ACTIVE), .ARRAY_ERROR(ARRAY_ERROR),
    .ARRAY_ADDR(ARRAY_ADDR), .PROGRAM_ACTIVE(PROGRAM_ACTIVE), .ERASE_ACTIVE(ERASE_ACTIVE),
    .ERASE_BLOCKS(ERASE_BLOCKS), .UNIT_ALIGNED(UNIT_ALIGNED), .SUPPLY_DOWN(SUPPLY_DOWN),
    .READ_ENABLE(READ_ENABLE), .BOOT_RATE_VALID(BOOT_RATE_VALID));

// File: tb/tb_top.sv
// testbench: register table, protection, decode, power-down and boot rate of the flash control block
module tb_top;
    import ofpec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // one register row: write byte flag, address, data, expected read back
    typedef struct packed {logic b; logic [15:0] a; logic [7:0] d; logic [7:0] e;} ofpec_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0, wr = 1'b0, byt = 1'b1, sub = 1'b0, osc = 1'b1, aerr = 1'b0, rxd = 1'b1;
    logic [15:0] addr = 16'h0000, aaddr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, rd;
    logic rdy, pact, eact, ualn, sdown, rden, rvalid;
    logic [NUM_BLOCKS-1:0] eblk;
    logic [15:0] period;
    logic [7:0] rdata_nf; // read data of the flashless instance
    logic eact_nf; // erase strobe of the flashless instance
    ofpec_mode_t mode = OFPEC_USER;
    int n_fail = 0;
    int n_checks = 0;
    // rows in order: refusals while closed, access and power writes with a word refusal, write enable refusals, then enabled writes up to an erase
    ofpec_row_t rows [17] = '{
        '{1'b0, 16'hf020, 8'h7f, 8'h00}, '{1'b1, 16'hf021, 8'hff, 8'h00}, '{1'b1, 16'hf022, 8'hff, 8'h00},
        '{1'b1, 16'hf023, 8'h01, 8'h00}, '{1'b1, 16'hf024, 8'hff, 8'h00}, '{1'b1, 16'hf02b, 8'hff, 8'h80},
        '{1'b1, 16'hf021, 8'hff, 8'h00}, '{1'b1, 16'hf022, 8'hff, 8'h80}, '{1'b0, 16'hf022, 8'h00, 8'h80},
        '{1'b1, 16'hf020, 8'h3f, 8'h00}, '{1'b1, 16'hf023, 8'h01, 8'h00}, '{1'b1, 16'hf020, 8'h40, 8'h40},
        '{1'b1, 16'hf020, 8'h42, 8'h40}, '{1'b1, 16'hf023, 8'h03, 8'h00}, '{1'b1, 16'hf023, 8'h04, 8'h04},
        '{1'b1, 16'hf020, 8'h60, 8'h60}, '{1'b1, 16'hf020, 8'h62, 8'h62}};
    // array addresses with expected alignment flag in bit 16
    logic [16:0] aln [6] = '{17'h10000, 17'h10080, 17'h00081, 17'h17f80, 17'h08000, 17'h00fff};
    ofpec_ctrl #(.IS_32K(1'b1), .HAS_FLASH(1'b1), .RATE_CNT_W(16)) dut (.CLOCK(clk), .RESET(rst),
        .BUS_SEL(sel), .BUS_WR(wr), .BUS_BYTE(byt), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_RDATA(rdata),
        .BUS_READY(rdy), .MODE(mode), .SUBACTIVE(sub), .SYS_OSC_ACTIVE(osc), .ARRAY_ERROR(aerr),
        .ARRAY_ADDR(aaddr), .BOOT_RXD(rxd), .PROGRAM_ACTIVE(pact), .ERASE_ACTIVE(eact), .ERASE_BLOCKS(eblk),
        .UNIT_ALIGNED(ualn), .SUPPLY_DOWN(sdown), .READ_ENABLE(rden), .BOOT_BIT_PERIOD(period),
        .BOOT_RATE_VALID(rvalid));
    // flashless variant on the same bus: filler reads, writes without effect
    ofpec_ctrl #(.IS_32K(1'b1), .HAS_FLASH(1'b0), .RATE_CNT_W(16)) dut_nf (.CLOCK(clk), .RESET(rst),
        .BUS_SEL(sel), .BUS_WR(wr), .BUS_BYTE(byt), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_RDATA(rdata_nf),
        .BUS_READY(), .MODE(mode), .SUBACTIVE(sub), .SYS_OSC_ACTIVE(osc), .ARRAY_ERROR(aerr),
        .ARRAY_ADDR(aaddr), .BOOT_RXD(rxd), .PROGRAM_ACTIVE(), .ERASE_ACTIVE(eact_nf), .ERASE_BLOCKS(),
        .UNIT_ALIGNED(), .SUPPLY_DOWN(), .READ_ENABLE(), .BOOT_BIT_PERIOD(), .BOOT_RATE_VALID());
    // 50 MHz system clock
    always #10 clk = ~clk;
    // single bit result compare
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1
    // byte result compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    // two state access: select held until ready is sampled high, data taken at that edge
    task automatic acc(input logic w, input logic b, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int waits;
        waits = 0;
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        byt <= b;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        // bounded wait, so a missing ready cannot hang the run
        while (rdy !== 1'b1 && waits < 4)
        begin
            @(posedge clk);
            waits++;
        end
        chk1(rdy, 1'b1);
        chk1(waits == 2, 1'b1);
        r = rdata;
        sel <= 1'b0;
    endtask : acc
    // counts, verdict and end of run
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // watchdog: the whole sequence needs well under ten microseconds
    initial
    begin
        #50us;
        n_fail++;
        test_done();
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            acc(1'b1, rows[i].b, rows[i].a, rows[i].d, rd);
            acc(1'b0, 1'b1, rows[i].a, 8'h00, rd);
            chk8(rd, rows[i].e);
            chk8(rdata_nf, 8'h00);
        end
        chk1(eact, 1'b1);
        chk1(eact_nf, 1'b0);
        chk1(pact, 1'b0);
        chk8({3'h0, eblk}, 8'h04);
        // alignment decode of program units
        foreach (aln[i])
        begin
            @(posedge clk);
            aaddr <= aln[i][15:0];
            repeat (2) @(posedge clk);
            #1;
            chk1(ualn, aln[i][16]);
        end
        // subactive: power bit set keeps supply up, cleared lets it drop, reads stay on
        @(posedge clk);
        sub <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk1(sdown, 1'b0);
        acc(1'b1, 1'b1, 16'hf022, 8'h00, rd);
        repeat (2) @(posedge clk);
        #1;
        chk1(sdown, 1'b1);
        chk1(rden, 1'b1);
        // array error in mid-erase
        @(posedge clk);
        sub <= 1'b0;
        aerr <= 1'b1;
        repeat (4) @(posedge clk);
        aerr <= 1'b0;
        #1;
        chk1(eact, 1'b0);
        acc(1'b0, 1'b1, 16'hf021, 8'h00, rd);
        chk8(rd, 8'h80);
        acc(1'b0, 1'b1, 16'hf020, 8'h00, rd);
        chk8(rd, 8'h40);
        // boot rate: a start bit of twenty cycles
        mode <= OFPEC_BOOT;
        rxd <= 1'b0;
        repeat (20) @(posedge clk);
        rxd <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk1(rvalid, 1'b1);
        chk1(period inside {[16'h0012:16'h0015]}, 1'b1);
        // second reset clears the error flag
        @(posedge clk);
        rst <= 1'b1;
        mode <= OFPEC_USER;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, 1'b1, 16'hf021, 8'h00, rd);
        chk8(rd, 8'h00);
        // program an aligned unit, then lose the system oscillator in mid-program
        acc(1'b1, 1'b1, 16'hf02b, 8'h80, rd);
        acc(1'b1, 1'b1, 16'hf020, 8'h40, rd);
        acc(1'b1, 1'b1, 16'hf020, 8'h50, rd);
        acc(1'b1, 1'b1, 16'hf020, 8'h51, rd);
        aaddr <= 16'h0080;
        repeat (2) @(posedge clk);
        #1;
        chk1(pact, 1'b1);
        @(posedge clk);
        osc <= 1'b0;
        repeat (3) @(posedge clk);
        osc <= 1'b1;
        #1;
        chk1(pact, 1'b0);
        acc(1'b0, 1'b1, 16'hf021, 8'h00, rd);
        chk8(rd, 8'h80);
        test_done();
    end
endmodule : tb_top
